// ==== rtl/anp_host_ctrl.sv ====
`timescale 1ns/1ps
module anp_host_ctrl (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic req_in,
   input wire anp_pkg::anp_cmd_t cmd_in,
   input wire logic sleep_in,
   output logic ready_out,
   output logic [anp_pkg::ANP_DW-1:0] rdata_out,
   output logic rdata_valid_out,
   output logic asleep_out,
   output anp_pkg::anp_pins_t pins_out,
   output logic [anp_pkg::ANP_DW-1:0] data_bus_out,
   output logic data_bus_oe_n_out,
   input wire logic [anp_pkg::ANP_DW-1:0] data_bus_in
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   anp_pkg::anp_state_t state_reg;
   anp_pkg::anp_state_t state_next;
   anp_pkg::anp_pins_t pins_reg;
   anp_pkg::anp_pins_t pins_next;
   anp_pkg::anp_cmd_t cmd_reg;
   logic pend_reg;
   logic pend_next;
   logic ready_reg;
   logic [anp_pkg::ANP_DW-1:0] dq_reg;
   logic [anp_pkg::ANP_DW-1:0] dq_next;
   logic dq_oe_n_reg;
   logic dq_oe_n_next;
   logic [anp_pkg::ANP_DW-1:0] rdata_reg;
   logic rvalid_reg;
   logic rvalid_next;
   logic asleep_reg;
   logic waking_reg;
   logic waking_next;
   logic acc_load;
   logic [anp_pkg::ANP_TW-1:0] acc_count;
   logic acc_done;
   logic cyc_load;
   logic [anp_pkg::ANP_TW-1:0] cyc_count;
   logic cyc_done;

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   wire take = req_in & ready_reg;
   wire same_row = (cmd_reg.addr[anp_pkg::ANP_AW-1:anp_pkg::ANP_COL_W] ==
                    pins_reg.addr[anp_pkg::ANP_AW-1:anp_pkg::ANP_COL_W]);
   wire start_ok = acc_done & cyc_done & ~waking_reg;
   wire [anp_pkg::ANP_TW-1:0] cycle_min = cmd_reg.we ? anp_pkg::ANP_WC_CYC
                                                      : anp_pkg::ANP_RC_CYC;

   ////////////////////////////////////////////////////////////////////////////
   // Timers: one for access, precharge and wake; one for random cycle spacing
   anp_wait_timer #(.W(anp_pkg::ANP_TW)) u_acc_timer (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .load_in(acc_load),
      .count_in(acc_count),
      .done_out(acc_done)
   );

   anp_wait_timer #(.W(anp_pkg::ANP_TW)) u_cyc_timer (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .load_in(cyc_load),
      .count_in(cyc_count),
      .done_out(cyc_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb
   begin
      state_next = state_reg;
      pins_next = pins_reg;
      pend_next = pend_reg | take;
      dq_next = dq_reg;
      dq_oe_n_next = dq_oe_n_reg;
      rvalid_next = 1'b0;
      waking_next = waking_reg & ~acc_done;
      acc_load = 1'b0;
      acc_count = anp_pkg::ANP_ZERO_CYC;
      cyc_load = 1'b0;
      cyc_count = anp_pkg::ANP_ZERO_CYC;
      case (state_reg)
         anp_pkg::ST_IDLE:
         begin
            if (pend_reg && start_ok)
            begin
               // Chip select falls with strobe high; output enable falls only for a read
               pins_next.chip_sel_n = 1'b0;
               pins_next.addr = cmd_reg.addr;
               pins_next.upper_byte_sel_n = cmd_reg.byte_sel_n[1];
               pins_next.lower_byte_sel_n = cmd_reg.byte_sel_n[0];
               pins_next.out_en_n = cmd_reg.we;
               acc_load = 1'b1;
               acc_count = anp_pkg::ANP_AA_CYC;
               cyc_load = 1'b1;
               cyc_count = cycle_min;
               pend_next = 1'b0;
               state_next = cmd_reg.we ? anp_pkg::ST_WR_SET : anp_pkg::ST_READ;
            end
            else if (!pend_reg && sleep_in && start_ok)
            begin
               pins_next.sleep_req_n = 1'b0;
               state_next = anp_pkg::ST_SLEEP;
            end
         end
         anp_pkg::ST_ROW_OPEN:
         begin
            // Row stays open with chip select low until told otherwise
            if (pend_reg && same_row)
            begin
               pins_next.addr = cmd_reg.addr;
               pins_next.upper_byte_sel_n = cmd_reg.byte_sel_n[1];
               pins_next.lower_byte_sel_n = cmd_reg.byte_sel_n[0];
               pins_next.out_en_n = cmd_reg.we;
               acc_load = 1'b1;
               acc_count = anp_pkg::ANP_AAP_CYC;
               pend_next = 1'b0;
               state_next = cmd_reg.we ? anp_pkg::ST_WR_SET : anp_pkg::ST_READ;
            end
            else if (pend_reg || sleep_in)
            begin
               // Close the row before another row or sleep
               pins_next.chip_sel_n = 1'b1;
               pins_next.out_en_n = 1'b1;
               pins_next.upper_byte_sel_n = 1'b1;
               pins_next.lower_byte_sel_n = 1'b1;
               acc_load = 1'b1;
               acc_count = anp_pkg::ANP_PC_CYC;
               state_next = anp_pkg::ST_PRECHARGE;
            end
         end
         anp_pkg::ST_READ:
         begin
            if (acc_done)
            begin
               rvalid_next = 1'b1;
               pins_next.out_en_n = 1'b1;
               state_next = anp_pkg::ST_ROW_OPEN;
            end
         end
         anp_pkg::ST_WR_SET:
         begin
            // Strobe falls after chip select, on the same edge that data starts being driven
            pins_next.write_strobe_n = 1'b0;
            dq_next = cmd_reg.wdata;
            dq_oe_n_next = 1'b0;
            state_next = anp_pkg::ST_WR_STROBE;
         end
         anp_pkg::ST_WR_STROBE:
         begin
            if (acc_done)
            begin
               pins_next.write_strobe_n = 1'b1;
               state_next = anp_pkg::ST_WR_RECOVER;
            end
         end
         anp_pkg::ST_WR_RECOVER:
         begin
            // Data held through the rising strobe, then released
            dq_oe_n_next = 1'b1;
            state_next = anp_pkg::ST_ROW_OPEN;
         end
         anp_pkg::ST_PRECHARGE:
         begin
            if (acc_done)
            begin
               state_next = anp_pkg::ST_IDLE;
            end
         end
         anp_pkg::ST_SLEEP:
         begin
            // Nothing but the sleep pin moves here
            if (!sleep_in)
            begin
               pins_next.sleep_req_n = 1'b1;
               acc_load = 1'b1;
               acc_count = anp_pkg::ANP_ZZEX_CYC;
               waking_next = 1'b1;
               state_next = anp_pkg::ST_IDLE;
            end
         end
         default:
         begin
            state_next = anp_pkg::ST_IDLE;
            pins_next = anp_pkg::ANP_PINS_RESET;
            dq_oe_n_next = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state_reg <= anp_pkg::ST_IDLE;
         pins_reg <= anp_pkg::ANP_PINS_RESET;
         pend_reg <= 1'b0;
         ready_reg <= 1'b0;
         dq_reg <= '0;
         dq_oe_n_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         asleep_reg <= 1'b0;
         waking_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         pins_reg <= pins_next;
         pend_reg <= pend_next;
         ready_reg <= ~pend_next;
         dq_reg <= dq_next;
         dq_oe_n_reg <= dq_oe_n_next;
         rvalid_reg <= rvalid_next;
         asleep_reg <= (state_next == anp_pkg::ST_SLEEP);
         waking_reg <= waking_next;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         cmd_reg <= '0;
         rdata_reg <= '0;
      end
      else
      begin
         if (take)
         begin
            cmd_reg <= cmd_in;
         end
         if (rvalid_next)
         begin
            rdata_reg <= data_bus_in;
         end
      end
   end

   assign ready_out = ready_reg;
   assign rdata_out = rdata_reg;
   assign rdata_valid_out = rvalid_reg;
   assign asleep_out = asleep_reg;
   assign pins_out = pins_reg;
   assign data_bus_out = dq_reg;
   assign data_bus_oe_n_out = dq_oe_n_reg;

endmodule : anp_host_ctrl

// ==== rtl/anp_pkg.sv ====
package anp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and memory shape
   localparam int ANP_AW = 16;
   localparam int ANP_DW = 16;
   localparam int ANP_COL_W = 2;
   localparam int ANP_TW = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Times in ns and their clock counts at 10 MHz
   localparam int ANP_CLK_PERIOD_NS = 100;
   localparam int ANP_ADDR_ACCESS_TIME_NS = 200;
   localparam int ANP_PAGE_ACCESS_TIME_NS = 100;
   localparam int ANP_PRECHARGE_MIN_TIME_NS = 100;
   localparam int ANP_READ_CYCLE_MIN_NS = 300;
   localparam int ANP_WRITE_CYCLE_MIN_NS = 300;
   localparam int ANP_SLEEP_EXIT_DELAY_NS = 500;

   // Least times round up, none below one cycle
   function automatic logic [ANP_TW-1:0] anp_cycles(input int t_ns);
      int c;
      c = (t_ns + ANP_CLK_PERIOD_NS - 1) / ANP_CLK_PERIOD_NS;
      if (c < 1)
      begin
         c = 1;
      end
      return ANP_TW'(c);
   endfunction : anp_cycles

   localparam logic [ANP_TW-1:0] ANP_AA_CYC = anp_cycles(ANP_ADDR_ACCESS_TIME_NS);
   localparam logic [ANP_TW-1:0] ANP_AAP_CYC = anp_cycles(ANP_PAGE_ACCESS_TIME_NS);
   localparam logic [ANP_TW-1:0] ANP_PC_CYC = anp_cycles(ANP_PRECHARGE_MIN_TIME_NS);
   localparam logic [ANP_TW-1:0] ANP_RC_CYC = anp_cycles(ANP_READ_CYCLE_MIN_NS);
   localparam logic [ANP_TW-1:0] ANP_WC_CYC = anp_cycles(ANP_WRITE_CYCLE_MIN_NS);
   localparam logic [ANP_TW-1:0] ANP_ZZEX_CYC = anp_cycles(ANP_SLEEP_EXIT_DELAY_NS);
   localparam logic [ANP_TW-1:0] ANP_ZERO_CYC = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic we;
      logic [1:0] byte_sel_n;
      logic [ANP_AW-1:0] addr;
      logic [ANP_DW-1:0] wdata;
   } anp_cmd_t;

   typedef struct packed {
      logic chip_sel_n;
      logic write_strobe_n;
      logic out_en_n;
      logic upper_byte_sel_n;
      logic lower_byte_sel_n;
      logic sleep_req_n;
      logic [ANP_AW-1:0] addr;
   } anp_pins_t;

   localparam anp_pins_t ANP_PINS_RESET = '{
      chip_sel_n: 1'b1,
      write_strobe_n: 1'b1,
      out_en_n: 1'b1,
      upper_byte_sel_n: 1'b1,
      lower_byte_sel_n: 1'b1,
      sleep_req_n: 1'b1,
      addr: 16'h0000
   };

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ROW_OPEN = 8'h02,
      ST_READ = 8'h04,
      ST_WR_SET = 8'h08,
      ST_WR_STROBE = 8'h10,
      ST_WR_RECOVER = 8'h20,
      ST_PRECHARGE = 8'h40,
      ST_SLEEP = 8'h80
   } anp_state_t;

endpackage : anp_pkg

// ==== rtl/anp_wait_timer.sv ====
`timescale 1ns/1ps
module anp_wait_timer #(
   parameter int W = 8
) (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic load_in,
   input wire logic [W-1:0] count_in,
   output logic done_out
);

   logic [W-1:0] cnt_reg;

   // Counts down to zero; done while at zero
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         cnt_reg <= '0;
      end
      else if (load_in)
      begin
         cnt_reg <= count_in;
      end
      else if (cnt_reg != '0)
      begin
         cnt_reg <= cnt_reg - W'(1);
      end
   end

   assign done_out = (cnt_reg == '0);

endmodule : anp_wait_timer

// ==== testbench/anp_host_ctrl_asserts.sv ====
`timescale 1ns/1ps
module anp_host_ctrl_asserts (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic rdata_valid_out,
   input wire anp_pkg::anp_pins_t pins_out,
   input wire logic [anp_pkg::ANP_DW-1:0] data_bus_out,
   input wire logic data_bus_oe_n_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_b_in);
   sequence s_wake;
      $rose(pins_out.sleep_req_n);
   endsequence
   sequence s_wr_end;
      $rose(pins_out.write_strobe_n);
   endsequence
   a_strobe_sel_low:
   assert property (!pins_out.write_strobe_n |-> !pins_out.chip_sel_n)
      else $error("strobe without select");
   a_bus_turn_safe:
   assert property (!data_bus_oe_n_out |-> pins_out.out_en_n)
      else $error("both sides drive");
   a_write_data_held:
   assert property (s_wr_end |-> !data_bus_oe_n_out && $stable(data_bus_out))
      else $error("write data moved");
   a_random_spacing:
   assert property ($fell(pins_out.chip_sel_n) |=> (!$fell(pins_out.chip_sel_n)) [*2])
      else $error("accesses too close");
   a_sleep_idle:
   assert property (!pins_out.sleep_req_n |-> pins_out.chip_sel_n && data_bus_oe_n_out)
      else $error("access during sleep");
   a_wake_gap:
   assert property (s_wake |-> pins_out.chip_sel_n [*5])
      else $error("access too soon after wake");
   a_valid_after_oe:
   assert property (rdata_valid_out |-> !$past(pins_out.out_en_n) && !$past(pins_out.out_en_n, 2))
      else $error("read without output enable");
   a_lane_sel:
   assert property ((!pins_out.out_en_n || !pins_out.write_strobe_n)
      |-> !(pins_out.upper_byte_sel_n && pins_out.lower_byte_sel_n))
      else $error("no lane selected");
   a_row_stable:
   assert property (!pins_out.chip_sel_n && !$past(pins_out.chip_sel_n)
      |-> $stable(pins_out.addr[15:2]))
      else $error("row moved while selected");
endmodule : anp_host_ctrl_asserts
////////////////////////////////////////////////////////////////////////////////
bind anp_host_ctrl anp_host_ctrl_asserts u_chk (
   .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .rdata_valid_out(rdata_valid_out),
   .pins_out(pins_out), .data_bus_out(data_bus_out), .data_bus_oe_n_out(data_bus_oe_n_out)
);

// ==== testbench/anp_mem_model.sv ====
`timescale 1ns/1ps
module anp_mem_model (
   input wire logic core_clk_in,
   input wire anp_pkg::anp_pins_t pins_in,
   input wire logic [15:0] host_data_in,
   input wire logic host_oe_n_in,
   output logic [15:0] bus_out
);
   logic [15:0] mem [0:65535];
   anp_pkg::anp_pins_t p = anp_pkg::ANP_PINS_RESET;
   realtime t_row = 0;
   realtime t_col = 0;
   logic [15:0] q = 16'h0f0f;
   assign bus_out = host_oe_n_in ? q : host_data_in;
   ////////////////////////////////////////////////////////////////////////////
   always @(pins_in)
   begin
      if (pins_in.sleep_req_n && p.sleep_req_n)
      begin
         if (!p.chip_sel_n && !p.write_strobe_n
            && (pins_in.write_strobe_n || pins_in.chip_sel_n))
         begin
            if (!p.upper_byte_sel_n)
               mem[p.addr][15:8] = bus_out[15:8];
            if (!p.lower_byte_sel_n)
               mem[p.addr][7:0] = bus_out[7:0];
         end
         if (!pins_in.chip_sel_n && (p.chip_sel_n || pins_in.addr[15:2] != p.addr[15:2]))
            t_row = $realtime;
         if (pins_in.addr[1:0] != p.addr[1:0])
            t_col = $realtime;
      end
      p = pins_in;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Released lanes toggle each cycle so stale data never looks like a read
   always @(negedge core_clk_in)
   begin
      q = ~q;
      if (!pins_in.chip_sel_n && !pins_in.out_en_n && pins_in.write_strobe_n
         && pins_in.sleep_req_n
         && $realtime - t_row >= anp_pkg::ANP_ADDR_ACCESS_TIME_NS - 50
         && $realtime - t_col >= anp_pkg::ANP_PAGE_ACCESS_TIME_NS - 50)
      begin
         if (!pins_in.upper_byte_sel_n)
            q[15:8] = mem[pins_in.addr][15:8];
         if (!pins_in.lower_byte_sel_n)
            q[7:0] = mem[pins_in.addr][7:0];
      end
   end
endmodule : anp_mem_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
   logic core_clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic req_in = 1'b0;
   logic sleep_in = 1'b0;
   anp_pkg::anp_cmd_t cmd_in = '0;
   anp_pkg::anp_pins_t pins_out;
   logic ready_out, rdata_valid_out, asleep_out, data_bus_oe_n_out;
   logic [15:0] rdata_out, data_bus_out, data_bus_in;
   wire logic [2:0] flags = {asleep_out, rdata_valid_out, ready_out};
   int num_errors = 0;
   int n_tests = 0;
   int n;
   always #50 core_clk_in = ~core_clk_in;
   anp_host_ctrl uut (
      .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .req_in(req_in), .cmd_in(cmd_in),
      .sleep_in(sleep_in), .ready_out(ready_out), .rdata_out(rdata_out),
      .rdata_valid_out(rdata_valid_out), .asleep_out(asleep_out), .pins_out(pins_out),
      .data_bus_out(data_bus_out), .data_bus_oe_n_out(data_bus_oe_n_out),
      .data_bus_in(data_bus_in)
   );
   anp_mem_model mdl (
      .core_clk_in(core_clk_in), .pins_in(pins_out), .host_data_in(data_bus_out),
      .host_oe_n_in(data_bus_oe_n_out), .bus_out(data_bus_in)
   );
   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("Checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // Bounded wait on ready, read valid or asleep; n counts the cycles
   task automatic wait_on(input int sel);
      for (n = 1; n < 60; n++)
      begin
         @(negedge core_clk_in);
         if (flags[sel] === 1'b1)
            return;
      end
      check("timeout", 1, 0);
      print_verdict();
   endtask : wait_on
   // Extra edge first so a stale ready from the last take is not reused
   task automatic issue(input anp_pkg::anp_cmd_t c);
      @(posedge core_clk_in);
      wait_on(0);
      @(posedge core_clk_in);
      req_in <= 1'b1;
      cmd_in <= c;
      @(posedge core_clk_in);
      req_in <= 1'b0;
   endtask : issue
   task automatic rd(input logic [15:0] a, input logic [1:0] b, input logic [15:0] e);
      logic [15:0] m;
      m = {{8{~b[1]}}, {8{~b[0]}}};
      issue({1'b0, b, a, 16'h0000});
      wait_on(1);
      check("read", e & m, rdata_out & m);
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      repeat (20) @(posedge core_clk_in);
      check("reset pins", anp_pkg::ANP_PINS_RESET, pins_out);
      check("reset ready", 0, ready_out);
      rst_b_in <= 1'b1;
   endtask : t_reset
   task automatic t_page;
      for (int c = 0; c < 4; c++)
         issue({1'b1, 2'b00, 16'h1230 + 16'(c), 16'hc0d0 + 16'(c)});
      for (int c = 3; c >= 0; c--)
         rd(16'h1230 + 16'(c), 2'b00, 16'hc0d0 + 16'(c));
      repeat (10) @(negedge core_clk_in);
      check("row open", 0, pins_out.chip_sel_n);
   endtask : t_page
   task automatic t_lanes;
      issue({1'b1, 2'b01, 16'h1231, 16'haa55});
      issue({1'b1, 2'b10, 16'h1231, 16'h1177});
      rd(16'h1231, 2'b00, 16'haa77);
      rd(16'h1231, 2'b01, 16'haa00);
   endtask : t_lanes
   task automatic t_rows;
      issue({1'b1, 2'b00, 16'h5678, 16'h0bad});
      rd(16'h1231, 2'b00, 16'haa77);
      rd(16'h5678, 2'b00, 16'h0bad);
   endtask : t_rows
   task automatic t_sleep;
      @(posedge core_clk_in);
      sleep_in <= 1'b1;
      wait_on(2);
      check("sleep pin", 0, pins_out.sleep_req_n);
      issue({1'b0, 2'b00, 16'h1230, 16'h0000});
      repeat (8) @(negedge core_clk_in);
      check("select asleep", 1, pins_out.chip_sel_n);
      @(posedge core_clk_in);
      sleep_in <= 1'b0;
      wait_on(1);
      check("wake gap", 1, n > anp_pkg::ANP_ZZEX_CYC + anp_pkg::ANP_AA_CYC);
      check("wake read", 16'hc0d0, rdata_out);
   endtask : t_sleep
   initial
   begin
      t_reset();
      t_page();
      t_lanes();
      t_rows();
      t_sleep();
      print_verdict();
   end
endmodule : tb
